// >>> logic/tsp_pkg.sv
// Constants, state codes and control carrier for the three-wire register port.
// Assumes one 40 MHz clock; serial pins arrive synchronous to it.
//
// Rules for this block and the master that drives it
// R1: Chip select high: pin released, port idle
// R2: Input bits sampled on serial clock rise
// R3: Read data changes on chosen clock edge
// R4: Master starts transfers in whole bytes
// R5: Chip select low enables port, pin input
// R6: Every field shifted least significant bit first
// R7: First bit direction, then seven address bits
// R8: After command, turn pin, shift register out
// R9: Reads auto-increment, up to 127 bytes
// R10: Store write byte after its eighth bit
// R11: Writes auto-increment the seven-bit address
// R12: Master ends transfers on byte boundaries
// R13: Master never writes addresses 0x78 upward
// R14: Master writes values, then sets init
// R15: Init bit restarts dividers, then self-clears
// R16: Outputs forced low during divider init
// R17: Pll_restart_trigger trigger separate access, self-clears
// R18: Master picks pulse mode before starting
// R19: Start bit launches pulses, then self-clears
// R20: Internal source immediate, external waits edge
// R21: Master may disable outputs around changes
package tsp_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int REG_COUNT = 128;
  localparam logic [6:0] READ_BLOCK_MAX = 7'h7f;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Control register locations and bit positions
  localparam logic [6:0] SREF_START_ADDR = 7'h70;
  localparam logic [6:0] GEN_CTRL_ADDR = 7'h71;
  localparam logic [6:0] SREF_CFG_ADDR = 7'h1c;
  localparam int START_BIT = 0;
  localparam int INIT_BIT = 0;
  localparam int PLL_RESTART_TRIGGER_BIT = 1;
  localparam int SRC_SEL_BIT = 0;
  localparam int MODE_SEL_BIT = 1;

  // Length of the divider restart window in clock cycles
  localparam int INIT_CYCLES = 16;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD = 4'b0010,
    ST_WDATA = 4'b0100,
    ST_RDATA = 4'b1000
  } tsp_state_e;

  typedef struct packed {
    logic div_restart;
    logic outputs_low;
    logic pll_restart;
    logic sysref_fire;
    logic sysref_pulse_mode_sel;
  } tsp_ctrl_s;

endpackage

// >>> logic/tsp_port.sv
// Three-wire serial register port with divider init, pll_restart_trigger and pulse start.
// Assumes serial pins are synchronous to mclk and slower than half its rate.
`timescale 1ns/10ps

module tsp_port
  import tsp_pkg::*;
#(
  parameter int INIT_LEN = INIT_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial pins
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // Configuration and events
  input wire logic read_edge_select,
  input wire logic external_reference_input,
  output tsp_ctrl_s ctrl,
  output logic init_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial framing

  tsp_state_e state;
  tsp_state_e next_state;
  logic sclk_q;
  logic ext_q;
  logic [2:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic [6:0] addr;
  logic [6:0] rd_cnt;
  logic [7:0] regs [REG_COUNT];
  logic [7:0] init_cnt;

  wire cs_act = ~chip_select_n;
  wire rise = sclk & ~sclk_q;
  wire fall = ~sclk & sclk_q;
  wire take = cs_act & rise;
  wire [7:0] rx_byte = {serial_data_in, rx_sh[7:1]};
  wire byte_end = take & (bit_cnt == LAST_BIT);
  wire in_cmd = (state == ST_IDLE) | (state == ST_CMD);
  wire cmd_end = byte_end & in_cmd;
  wire cmd_rd = rx_byte[0];
  wire [6:0] cmd_addr = rx_byte[7:1];
  wire wr_en = byte_end & (state == ST_WDATA);
  wire rd_more = rd_cnt != READ_BLOCK_MAX;
  wire rd_load = (cmd_end & cmd_rd) | (byte_end & (state == ST_RDATA) & rd_more);
  wire [7:0] rd_data = (state == ST_RDATA) ? regs[addr] : regs[cmd_addr];
  wire shift_edge = cs_act & (state == ST_RDATA) & (read_edge_select ? rise : fall);

  always_comb
  begin
    next_state = state;
    if (!cs_act)
      next_state = ST_IDLE;
    else
      unique case (state)
        ST_IDLE: next_state = ST_CMD;
        ST_CMD: next_state = cmd_end ? (cmd_rd ? ST_RDATA : ST_WDATA) : ST_CMD;
        ST_WDATA: next_state = ST_WDATA;
        ST_RDATA: next_state = ST_RDATA;
      endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      sclk_q <= 1'b0;
      bit_cnt <= 3'h0;
      rx_sh <= 8'h00;
    end
    else
    begin
      state <= next_state;
      sclk_q <= sclk;
      // R2: sample on rise
      if (!cs_act)
        bit_cnt <= 3'h0;
      else if (take)
        bit_cnt <= bit_cnt + 3'h1;
      // R6: shift in LSB first
      if (take)
        rx_sh <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address pointer and read shifter

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      addr <= 7'h00;
      rd_cnt <= 7'h00;
      tx_sh <= 8'h00;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
    end
    else
    begin
      // R7: direction then address
      if (cmd_end)
        addr <= cmd_rd ? 7'(cmd_addr + 7'h1) : cmd_addr;
      // R9 R11: auto-increment
      else if (wr_en | (rd_load & (state == ST_RDATA)))
        addr <= 7'(addr + 7'h1);
      if (cmd_end)
        rd_cnt <= 7'h01;
      else if (rd_load)
        rd_cnt <= 7'(rd_cnt + 7'h1);
      // R3: edge chosen by select; on rising mode bit 0 leaves with the load
      if (rd_load & read_edge_select)
      begin
        serial_data_out <= rd_data[0];
        tx_sh <= {1'b0, rd_data[7:1]};
      end
      else if (rd_load)
        tx_sh <= rd_data;
      else if (shift_edge)
      begin
        serial_data_out <= tx_sh[0];
        tx_sh <= {1'b0, tx_sh[7:1]};
      end
      // R1 R5: released while deselected; R8: driven after read command
      if (!cs_act)
        serial_data_oe <= 1'b0;
      else if (rd_load)
        serial_data_oe <= 1'b1;
      else if (byte_end & (state == ST_RDATA))
        serial_data_oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and self-clearing controls

  wire init_req = regs[GEN_CTRL_ADDR][INIT_BIT];
  wire pll_restart_trigger_req = regs[GEN_CTRL_ADDR][PLL_RESTART_TRIGGER_BIT];
  wire start_req = regs[SREF_START_ADDR][START_BIT];
  wire src_ext = regs[SREF_CFG_ADDR][SRC_SEL_BIT];
  wire ext_rise = external_reference_input & ~ext_q;
  wire init_done = init_busy & (init_cnt == 8'h00);
  wire init_start = init_req & ~init_busy;
  // R20: internal source fires at once, external waits for its edge
  wire fire = start_req & (~src_ext | ext_rise);

  // Clears come first so a write in the same cycle wins over them
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        regs[i] <= REG_RESET;
    end
    else
    begin
      // R15: init self-clears
      if (init_done)
        regs[GEN_CTRL_ADDR][INIT_BIT] <= 1'b0;
      // R17: trigger self-clears
      if (pll_restart_trigger_req)
        regs[GEN_CTRL_ADDR][PLL_RESTART_TRIGGER_BIT] <= 1'b0;
      // R19: start self-clears
      if (fire)
        regs[SREF_START_ADDR][START_BIT] <= 1'b0;
      // R10: store completed byte
      if (wr_en)
        regs[addr] <= rx_byte;
    end
  end

  logic div_restart;
  logic pll_restart;
  logic sysref_fire;
  logic mode_sel;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      init_busy <= 1'b0;
      init_cnt <= 8'h00;
      div_restart <= 1'b0;
      pll_restart <= 1'b0;
      sysref_fire <= 1'b0;
      mode_sel <= 1'b0;
      ext_q <= 1'b0;
    end
    else
    begin
      ext_q <= external_reference_input;
      // R15 R16: restart window holds outputs low
      if (init_start)
      begin
        init_busy <= 1'b1;
        init_cnt <= 8'(INIT_LEN - 1);
      end
      else if (init_done)
        init_busy <= 1'b0;
      else if (init_busy)
        init_cnt <= 8'(init_cnt - 8'h1);
      div_restart <= init_start;
      pll_restart <= pll_restart_trigger_req;
      sysref_fire <= fire;
      mode_sel <= regs[SREF_CFG_ADDR][MODE_SEL_BIT];
    end
  end

  assign ctrl = '{div_restart: div_restart, outputs_low: init_busy, pll_restart: pll_restart,
                  sysref_fire: sysref_fire, sysref_pulse_mode_sel: mode_sel};

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_pin_released: assert property (chip_select_n |=> !serial_data_oe) // R1
    else $error("data pin driven while deselected");
  a_sample_rise: assert property (take |=> rx_sh[7] == $past(serial_data_in)) // R2
    else $error("input bit not sampled on rise");
  a_out_edge: assert property ($changed(serial_data_out) |-> // R3
    $past(sclk != sclk_q && sclk == read_edge_select))
    else $error("read data changed off its edge");
  a_read_turn: assert property (cmd_end && cmd_rd |=> serial_data_oe && state == ST_RDATA) // R8
    else $error("read command did not turn the pin");
  a_write_store: assert property (wr_en |=> regs[$past(addr)] == $past(rx_byte)) // R10
    else $error("write byte not stored");
  a_addr_step: assert property (wr_en |=> addr == 7'($past(addr) + 7'h1)) // R11
    else $error("write address did not advance");
  a_init_span: assert property ($rose(init_busy) |-> ctrl.outputs_low [*8]) // R16
    else $error("outputs not held low during init");
  a_init_clear: assert property (init_done && !wr_en |=> !init_req) // R15
    else $error("init bit did not self-clear");
  a_pll_restart_trigger_pulse: assert property (pll_restart_trigger_req |=> // R17
    pll_restart ##1 (!pll_restart || pll_restart_trigger_req))
    else $error("pll_restart_trigger trigger not a single pulse");
  a_start_int: assert property (start_req && !src_ext |=> sysref_fire) // R19
    else $error("internal start did not fire");
  a_start_ext: assert property (start_req && src_ext && !ext_rise |=> !sysref_fire) // R20
    else $error("external start fired without edge");

  c_read: cover property (cmd_end && cmd_rd ##[1:400] byte_end && state == ST_RDATA);
  c_write: cover property (wr_en);
  c_init: cover property ($fell(init_busy));
  c_ext_fire: cover property (start_req && src_ext && ext_rise);

endmodule

// >>> verif/tsp_master.sv
// Behavioural serial master driving the three-wire register port.
// Assumes the bench calls its tasks; mclk paces every pin change.
`timescale 1ns/10ps

module tsp_master (
  // Clock
  input wire logic mclk,
  // Serial pins
  output logic sclk,
  output logic chip_select_n,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe
);
  logic drv;
  logic last;

  // Released pin shows the inverse of its last level, not a kind constant
  assign serial_data_in = serial_data_oe ? serial_data_out : (chip_select_n ? ~last : drv);

  initial
  begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    drv = 1'b0;
    last = 1'b0;
  end

  always @(posedge mclk) last <= serial_data_in;

  task automatic select(input logic on);
    @(posedge mclk);
    chip_select_n <= ~on;
    repeat (2) @(posedge mclk);
  endtask

  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 0; i < 8; i++)
    begin
      drv <= tx[i];
      repeat (2) @(posedge mclk);
      rx[i] = serial_data_in;
      sclk <= 1'b1;
      repeat (2) @(posedge mclk);
      sclk <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
endmodule

// >>> verif/test_three_wire_serial_reg_port.sv
// Self-checking bench for the three-wire register port.
// Assumes tsp_master as far side and a short init window.
`timescale 1ns/10ps

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end

module test_three_wire_serial_reg_port;
  import tsp_pkg::*;
  localparam int INIT_N = 8;
  logic mclk, rst, sclk, chip_select_n, serial_data_in, serial_data_out, serial_data_oe;
  logic read_edge_select, external_reference_input, init_busy;
  tsp_ctrl_s ctrl;
  logic [7:0] wbuf [4];
  logic [7:0] rbuf [4];
  logic [7:0] rx;
  logic [6:0] a;
  int fails, compares, cycles, seed;
  integer n_div = 0;
  integer n_pll = 0;
  integer n_fire = 0;
  integer n_busy = 0;

  tsp_port #(.INIT_LEN(INIT_N)) dut_u (.mclk(mclk), .rst(rst), .sclk(sclk),
    .chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .read_edge_select(read_edge_select), .external_reference_input(external_reference_input),
    .ctrl(ctrl), .init_busy(init_busy));

  tsp_master m_u (.mclk(mclk), .sclk(sclk), .chip_select_n(chip_select_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse counters and hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (!rst)
    begin
      n_div += ctrl.div_restart;
      n_pll += ctrl.pll_restart;
      n_fire += ctrl.sysref_fire;
      n_busy += (init_busy && ctrl.outputs_low);
    end
    if (cycles == 20000)
    begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic burst(input logic rd, input logic [6:0] ad, input int n);
    m_u.select(1'b1);
    m_u.byte_io({ad, rd}, rx);
    for (int i = 0; i < n; i++)
      m_u.byte_io(wbuf[i], rbuf[i]);
    m_u.select(1'b0);
  endtask

  task automatic wr1(input logic [6:0] ad, input logic [7:0] d);
    wbuf[0] = d;
    burst(1'b0, ad, 1);
  endtask

  // Internal source fires at once, external only once an edge was seen
  function automatic int exp_fire(input int prior, input logic ext_src, input logic edge_seen);
    return prior + int'(!ext_src || edge_seen);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    read_edge_select = 1'b0;
    external_reference_input = 1'b0;
    seed = 32'ha6b4bf9c;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK({ctrl, init_busy, serial_data_oe}, 7'h00)
    for (int k = 0; k < 4; k++)
    begin
      a = 7'h20 + 7'($random(seed) & 32'h3f);
      for (int i = 0; i < 4; i++)
        wbuf[i] = 8'($random(seed));
      burst(1'b0, a, 4);
      read_edge_select <= k[0];
      burst(1'b1, a, 4);
      for (int i = 0; i < 4; i++)
        `CHK(rbuf[i], wbuf[i])
      `CHK(serial_data_oe, 1'b0)
    end
    // Init command clocked with select high must be ignored
    m_u.byte_io(8'he2, rx);
    m_u.byte_io(8'h01, rx);
    `CHK(n_div, 0)
    wr1(7'h74, 8'h00);
    wr1(7'h71, 8'h01);
    repeat (INIT_N + 4) @(posedge mclk);
    `CHK(n_busy, INIT_N)
    `CHK(n_div, 1)
    burst(1'b1, 7'h71, 1);
    `CHK(rbuf[0], 8'h00)
    wr1(7'h71, 8'h02);
    repeat (4) @(posedge mclk);
    `CHK(n_pll, 1)
    wr1(7'h74, 8'hff);
    wr1(7'h1c, 8'h02);
    `CHK(ctrl.sysref_pulse_mode_sel, 1'b1)
    wr1(7'h70, 8'h01);
    repeat (4) @(posedge mclk);
    `CHK(n_fire, exp_fire(0, 1'b0, 1'b0))
    wr1(7'h1c, 8'h01);
    wr1(7'h70, 8'h01);
    repeat (10) @(posedge mclk);
    `CHK(n_fire, exp_fire(1, 1'b1, 1'b0))
    external_reference_input <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(n_fire, exp_fire(1, 1'b1, 1'b1))
    external_reference_input <= 1'b0;
    burst(1'b1, 7'h70, 1);
    `CHK(rbuf[0], 8'h00)
    burst(1'b1, 7'h74, 1);
    `CHK(rbuf[0], 8'hff)
    wrap_up();
  end
endmodule
